// ### logic/mcc_regs.svh
// offsets, field positions and reset values of the motor control bank
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define MCC_ADDR_SYS_CTRL      8'h9E
`define MCC_ADDR_TEST_CTRL     8'hAE
`define MCC_ADDR_COIL_CTRL     8'hBE
`define MCC_ADDR_REVISION      8'hFF

// ----------------------------------------------------------------------
// system control fields
// ----------------------------------------------------------------------
`define MCC_SYS_PARK_A         0
`define MCC_SYS_PARK_B         1
`define MCC_SYS_CALIB_REF      2
`define MCC_SYS_RETRACT_A      3
`define MCC_SYS_START_DOUBLE   4
`define MCC_SYS_COIL_EN        5
`define MCC_SYS_RETRACT_B      6
`define MCC_SYS_RETRACT_CMD    7

// ----------------------------------------------------------------------
// test control fields
// ----------------------------------------------------------------------
`define MCC_TST_DIAG_SEL       4
`define MCC_TST_REV_STOP       5
`define MCC_TST_BOOST_DIS      7

// ----------------------------------------------------------------------
// voice-coil control fields
// ----------------------------------------------------------------------
`define MCC_VCC_CHOP_SLEW      0
`define MCC_VCC_FORCE_HIGH     1
`define MCC_VCC_COMM_SLEW      3

// ----------------------------------------------------------------------
// reset values and identity
// ----------------------------------------------------------------------
`define MCC_REG_RESET          8'h00
// revision code value is arbitrary
`define MCC_REVISION_CODE      8'h01
`define MCC_FRAME_LAST_BIT     3'h7

`endif

// ### logic/mcc_pkg.sv
// types shared by the motor combo control bank
package mcc_pkg;

	// serial port frame states
	typedef enum logic [1:0] {
		SER_IDLE,
		SER_ADDR,
		SER_DATA,
		SER_DONE
	} mcc_ser_state_type;

endpackage

// ### logic/mcc_ser_if.sv
// link between the serial port engine and the register core
`timescale 1ns/100ps

interface mcc_ser_if;
	logic       wr_stb;   // one-cycle write strobe
	logic [7:0] wr_addr;  // register address of the frame
	logic [7:0] wr_data;  // write data
	logic       rd_req;   // one-cycle read request
	logic [7:0] rd_data;  // read data from the core

	modport port (
		output wr_stb,
		output wr_addr,
		output wr_data,
		output rd_req,
		input  rd_data
	);

	modport core (
		input  wr_stb,
		input  wr_addr,
		input  wr_data,
		input  rd_req,
		output rd_data
	);
endinterface

// ### logic/mcc_serial_port.sv
// serial register port engine: address byte then data byte, msb first
`timescale 1ns/100ps
`include "mcc_regs.svh"

module mcc_serial_port (
	input  wire logic sys_clk,    // system clock
	input  wire logic rst,        // synchronous reset
	input  wire logic ser_sel_n,  // frame select, low active
	input  wire logic ser_clk,    // serial bit clock
	input  wire logic ser_din,    // serial data in
	output logic      ser_dout,   // serial data out
	output logic      ser_oe,     // data out enable
	mcc_ser_if.port   bus         // to register core
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	mcc_pkg::mcc_ser_state_type state_q, state_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] in_sh_q, in_sh_d;
	logic [7:0] out_sh_q, out_sh_d;
	logic [7:0] addr_q, addr_d;
	logic [7:0] data_q, data_d;
	logic       rd_q, rd_d;
	logic       sclk_q, sclk_d;
	logic       stb_q, stb_d;
	logic       req_q, req_d;
	logic       dout_q, dout_d;
	logic       oe_q, oe_d;
	logic       rise;
	logic [7:0] sh_next;

	// bit clock rising edge inside a frame
	assign rise    = ser_clk & ~sclk_q & ~ser_sel_n;
	assign sh_next = {in_sh_q[6:0], ser_din};

	// next-state logic of the frame engine
	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		in_sh_d  = in_sh_q;
		out_sh_d = out_sh_q;
		addr_d   = addr_q;
		data_d   = data_q;
		rd_d     = rd_q;
		sclk_d   = ser_clk;
		stb_d    = 1'b0;
		req_d    = 1'b0;
		dout_d   = dout_q;
		oe_d     = oe_q;
		case (state_q)
			mcc_pkg::SER_IDLE: begin
				cnt_d = 3'h0;
				oe_d  = 1'b0;
				rd_d  = 1'b0;
				if (!ser_sel_n) begin
					state_d = mcc_pkg::SER_ADDR;
				end
			end
			mcc_pkg::SER_ADDR: begin
				if (ser_sel_n) begin
					state_d = mcc_pkg::SER_IDLE;
				end else if (rise) begin
					in_sh_d = sh_next;
					cnt_d   = cnt_q + 3'h1;
					if (cnt_q == `MCC_FRAME_LAST_BIT) begin
						addr_d  = sh_next;
						state_d = mcc_pkg::SER_DATA;
						// revision address turns the frame into a read
						if (sh_next == `MCC_ADDR_REVISION) begin
							rd_d     = 1'b1;
							req_d    = 1'b1;
							out_sh_d = bus.rd_data;
							dout_d   = bus.rd_data[7];
							oe_d     = 1'b1;
						end
					end
				end
			end
			mcc_pkg::SER_DATA: begin
				if (ser_sel_n) begin
					state_d = mcc_pkg::SER_IDLE;
					oe_d    = 1'b0;
				end else if (rise) begin
					in_sh_d  = sh_next;
					cnt_d    = cnt_q + 3'h1;
					out_sh_d = {out_sh_q[6:0], 1'b0};
					dout_d   = rd_q & out_sh_q[6];
					if (cnt_q == `MCC_FRAME_LAST_BIT) begin
						data_d  = sh_next;
						stb_d   = ~rd_q;
						state_d = mcc_pkg::SER_DONE;
						oe_d    = 1'b0;
					end
				end
			end
			mcc_pkg::SER_DONE: begin
				oe_d = 1'b0;
				if (ser_sel_n) begin
					state_d = mcc_pkg::SER_IDLE;
				end
			end
			default: begin
				state_d = mcc_pkg::SER_IDLE;
			end
		endcase
	end

	// registers of the frame engine
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q  <= mcc_pkg::SER_IDLE;
			cnt_q    <= 3'h0;
			in_sh_q  <= 8'h00;
			out_sh_q <= 8'h00;
			addr_q   <= 8'h00;
			data_q   <= 8'h00;
			rd_q     <= 1'b0;
			sclk_q   <= 1'b0;
			stb_q    <= 1'b0;
			req_q    <= 1'b0;
			dout_q   <= 1'b0;
			oe_q     <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			in_sh_q  <= in_sh_d;
			out_sh_q <= out_sh_d;
			addr_q   <= addr_d;
			data_q   <= data_d;
			rd_q     <= rd_d;
			sclk_q   <= sclk_d;
			stb_q    <= stb_d;
			req_q    <= req_d;
			dout_q   <= dout_d;
			oe_q     <= oe_d;
		end
	end

	assign bus.wr_stb  = stb_q;
	assign bus.wr_addr = addr_q;
	assign bus.wr_data = data_q;
	assign bus.rd_req  = req_q;
	assign ser_dout    = dout_q;
	assign ser_oe      = oe_q;

endmodule

// ### logic/mcc_ctrl_regs.sv
// motor combo control register bank with serial register port
// Contract
// R1 - calibration bit one connects two-volt reference to level shifter
// R2 - system bit 4 doubles spindle align and energization durations
// R3 - system bit 5 enables the voice-coil section, zero disables it
// R4 - software writes speed-loop register bit 2 zero with retract-time bits
// R5 - test bit 4 picks speed signal when one, zero-crossing when zero
// R6 - test bit 5 written one commands the spindle reverse brake
// R7 - software clears reverse-brake bit before start-up is enabled again
// R8 - coil bit 0 picks slow chop slew when zero, fast when one
// R9 - coil bit 1 forces both coil outputs high in phase-shift mode
// R10 - coil bit 3 picks fast commutation slew at zero, slow at one
// R11 - read-only eight-bit revision register at address FFh
// R12 - software writes unused bits zero and keeps a shadow copy
`timescale 1ns/100ps
`include "mcc_regs.svh"

module mcc_ctrl_regs #(
	parameter logic [7:0] REVISION = `MCC_REVISION_CODE  // arbitrary value
) (
	input  wire logic sys_clk,                  // 20 MHz system clock
	input  wire logic rst,                      // synchronous reset, high
	input  wire logic ser_sel_n,                // serial frame select, low
	input  wire logic ser_clk,                  // serial bit clock
	input  wire logic ser_din,                  // serial data in
	output logic      ser_dout,                 // serial data out
	output logic      ser_oe,                   // serial data out enable
	input  wire logic psm_mode,                 // coil in phase-shift mode
	input  wire logic spindle_speed_sig,        // spindle mech/elec speed
	input  wire logic spindle_zero_cross,       // spindle zero crossing
	output logic      park_level_sel_a,         // parking voltage select a
	output logic      park_level_sel_b,         // parking voltage select b
	output logic      calib_reference_connect,  // reference to level shift
	output logic      retract_duration_sel_a,   // retract time select a
	output logic      retract_duration_sel_b,   // retract time select b
	output logic      start_timing_double,      // doubled start-up timing
	output logic      coil_enable,              // voice-coil section on
	output logic      retract_cmd,              // voice-coil retract
	output logic      diag_output_select,       // diagnostic source select
	output logic      spindle_reverse_stop,     // spindle reverse brake
	output logic      boost_disable,            // boost supply off
	output logic      coil_chop_slew_sel,       // chop slew fast when high
	output logic      coil_outputs_force_high,  // both coil outputs high
	output logic      commutation_slew_sel,     // commutation slew slow
	output logic      spindle_diag_output_pin   // diagnostic output
);

	// ------------------------------------------------------------------
	// serial port engine
	// ------------------------------------------------------------------
	mcc_ser_if ser ();

	mcc_serial_port u_port (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.ser_sel_n (ser_sel_n),
		.ser_clk   (ser_clk),
		.ser_din   (ser_din),
		.ser_dout  (ser_dout),
		.ser_oe    (ser_oe),
		.bus       (ser.port)
	);

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	logic [7:0] sys_q, sys_d;
	logic [7:0] tst_q, tst_d;
	logic [7:0] vcc_q, vcc_d;
	logic       diag_q, diag_d;
	logic       force_q, force_d;

	// write strobe aimed at one register address
	function automatic logic reg_hit(input logic stb,
	                                 input logic [7:0] addr,
	                                 input logic [7:0] target);
		reg_hit = stb & (addr == target);
	endfunction

	// write decode and derived outputs
	always_comb begin
		sys_d = sys_q;
		tst_d = tst_q;
		vcc_d = vcc_q;
		if (reg_hit(ser.wr_stb, ser.wr_addr, `MCC_ADDR_SYS_CTRL)) begin
			sys_d = ser.wr_data;  // R1 R2 R3
		end
		if (reg_hit(ser.wr_stb, ser.wr_addr, `MCC_ADDR_TEST_CTRL)) begin
			tst_d = ser.wr_data;  // R6
		end
		if (reg_hit(ser.wr_stb, ser.wr_addr, `MCC_ADDR_COIL_CTRL)) begin
			vcc_d = ser.wr_data;  // R8 R10
		end
		// diagnostic source select
		diag_d = tst_q[`MCC_TST_DIAG_SEL] ? spindle_speed_sig
		                                  : spindle_zero_cross;  // R5
		// forcing applies only in phase-shift mode
		force_d = vcc_q[`MCC_VCC_FORCE_HIGH] & psm_mode;  // R9
	end

	// power-on state clears every control register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sys_q   <= `MCC_REG_RESET;
			tst_q   <= `MCC_REG_RESET;
			vcc_q   <= `MCC_REG_RESET;
			diag_q  <= 1'b0;
			force_q <= 1'b0;
		end else begin
			sys_q   <= sys_d;
			tst_q   <= tst_d;
			vcc_q   <= vcc_d;
			diag_q  <= diag_d;
			force_q <= force_d;
		end
	end

	// revision register is a constant; writes to it are ignored
	assign ser.rd_data = REVISION;  // R11

	// ------------------------------------------------------------------
	// output fields
	// ------------------------------------------------------------------
	assign park_level_sel_a        = sys_q[`MCC_SYS_PARK_A];
	assign park_level_sel_b        = sys_q[`MCC_SYS_PARK_B];
	assign calib_reference_connect = sys_q[`MCC_SYS_CALIB_REF];     // R1
	assign retract_duration_sel_a  = sys_q[`MCC_SYS_RETRACT_A];
	assign retract_duration_sel_b  = sys_q[`MCC_SYS_RETRACT_B];
	assign start_timing_double     = sys_q[`MCC_SYS_START_DOUBLE];  // R2
	assign coil_enable             = sys_q[`MCC_SYS_COIL_EN];       // R3
	assign retract_cmd             = sys_q[`MCC_SYS_RETRACT_CMD];
	assign diag_output_select      = tst_q[`MCC_TST_DIAG_SEL];      // R5
	assign spindle_reverse_stop    = tst_q[`MCC_TST_REV_STOP];      // R6
	assign boost_disable           = tst_q[`MCC_TST_BOOST_DIS];
	assign coil_chop_slew_sel      = vcc_q[`MCC_VCC_CHOP_SLEW];     // R8
	assign coil_outputs_force_high = force_q;                       // R9
	assign commutation_slew_sel    = vcc_q[`MCC_VCC_COMM_SLEW];     // R10
	assign spindle_diag_output_pin = diag_q;                        // R5

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_calib_ref_write: assert property (  // R1
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_SYS_CTRL |=>
		calib_reference_connect == $past(ser.wr_data[`MCC_SYS_CALIB_REF]))
		else $error("calibration reference bit not taken");

	a_start_double_write: assert property (  // R2
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_SYS_CTRL |=>
		start_timing_double == $past(ser.wr_data[`MCC_SYS_START_DOUBLE]))
		else $error("start-up doubling bit not taken");

	a_coil_enable_hold: assert property (  // R3
		@(posedge sys_clk) disable iff (rst)
		!(ser.wr_stb && ser.wr_addr == `MCC_ADDR_SYS_CTRL) |=>
		$stable(coil_enable))
		else $error("coil enable changed without a write");

	a_coil_enable_write: assert property (  // R3
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_SYS_CTRL |=>
		coil_enable == $past(ser.wr_data[`MCC_SYS_COIL_EN]))
		else $error("coil enable bit not taken");

	a_park_level_write: assert property (
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_SYS_CTRL |=>
		{park_level_sel_b, park_level_sel_a} == $past(ser.wr_data[1:0]))
		else $error("parking level bits not taken");

	a_retract_write: assert property (
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_SYS_CTRL |=>
		{retract_cmd, retract_duration_sel_b, retract_duration_sel_a} ==
		{$past(ser.wr_data[7]), $past(ser.wr_data[6]),
		 $past(ser.wr_data[3])})
		else $error("retract bits not taken");

	a_diag_sel_write: assert property (  // R5
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_TEST_CTRL |=>
		diag_output_select == $past(ser.wr_data[`MCC_TST_DIAG_SEL]))
		else $error("diagnostic select bit not taken");

	a_diag_mux_path: assert property (  // R5
		@(posedge sys_clk) disable iff (rst)
		##1 spindle_diag_output_pin ==
		($past(diag_output_select) ? $past(spindle_speed_sig)
		                           : $past(spindle_zero_cross)))
		else $error("diagnostic output source wrong");

	a_spindle_reverse_stop_write: assert property (  // R6
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_TEST_CTRL &&
		ser.wr_data[`MCC_TST_REV_STOP] |=>
		spindle_reverse_stop ##1 spindle_reverse_stop)
		else $error("reverse brake not commanded");

	a_spindle_reverse_stop_clear: assert property (  // R6
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_TEST_CTRL &&
		!ser.wr_data[`MCC_TST_REV_STOP] |=>
		!spindle_reverse_stop)
		else $error("reverse brake not released");

	a_boost_dis_write: assert property (
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_TEST_CTRL |=>
		boost_disable == $past(ser.wr_data[`MCC_TST_BOOST_DIS]))
		else $error("boost disable bit not taken");

	a_chop_slew_write: assert property (  // R8
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_COIL_CTRL |=>
		coil_chop_slew_sel == $past(ser.wr_data[`MCC_VCC_CHOP_SLEW]))
		else $error("chop slew bit not taken");

	a_force_high_mode: assert property (  // R9
		@(posedge sys_clk) disable iff (rst)
		##1 coil_outputs_force_high ==
		($past(psm_mode) && $past(vcc_q[`MCC_VCC_FORCE_HIGH])))
		else $error("coil force high not tied to phase-shift mode");

	a_comm_slew_write: assert property (  // R10
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr == `MCC_ADDR_COIL_CTRL |=>
		commutation_slew_sel == $past(ser.wr_data[`MCC_VCC_COMM_SLEW]))
		else $error("commutation slew bit not taken");

	a_revision_read: assert property (  // R11
		@(posedge sys_clk) disable iff (rst)
		ser.rd_req |-> ser_oe && ser_dout == REVISION[7])
		else $error("revision read not driven");

	a_other_addr_hold: assert property (
		@(posedge sys_clk) disable iff (rst)
		ser.wr_stb && ser.wr_addr != `MCC_ADDR_SYS_CTRL &&
		ser.wr_addr != `MCC_ADDR_TEST_CTRL &&
		ser.wr_addr != `MCC_ADDR_COIL_CTRL |=>
		$stable(sys_q) && $stable(tst_q) && $stable(vcc_q))
		else $error("write to a foreign address changed a register");

endmodule

// ### sim/mcc_host_model.sv
// host processor model driving the serial register port
`timescale 1ns/100ps

module mcc_host_model (
	input  wire logic sys_clk,    // system clock
	output logic      ser_sel_n,  // frame select, low
	output logic      ser_clk,    // serial bit clock
	output logic      ser_din,    // serial data to device
	input  wire logic ser_dout,   // serial data from device
	input  wire logic ser_oe      // device drives ser_dout
);
	// idle frame lines
	initial begin
		ser_sel_n = 1'b1;
		ser_clk   = 1'b0;
		ser_din   = 1'b0;
	end

	// one frame of nb rises, msb first; read bits taken on clock falls
	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
			input int nb, output logic [7:0] q, output logic oe_bad);
		logic [15:0] w;
		int          i;
		w = {a, d};
		q = 8'h00;
		oe_bad = 1'b0;
		for (i = 0; i <= nb; i++) begin
			@(posedge sys_clk);
			ser_sel_n <= (i == nb);
			ser_clk   <= 1'b0;
			// released data line shows the inverse of its last bit
			ser_din   <= (i < nb) ? w[15 - i] : ~ser_din;
			@(negedge sys_clk);
			if (i >= 8 && i <= 15 && i <= nb)
				q[15 - i] = ser_dout;
			if (i >= 1)
				oe_bad |= ser_oe !== (a == 8'hFF && i >= 8 && i <= 15);
			if (i < nb) begin
				// two cycles low, two cycles high
				@(posedge sys_clk);
				@(posedge sys_clk);
				ser_clk <= 1'b1;
				@(posedge sys_clk);
			end
		end
		repeat (2) @(posedge sys_clk);
	endtask
endmodule

// ### sim/mcc_ctrl_regs_tb_top.sv
// self-checking testbench of the motor combo control register bank
`timescale 1ns/100ps

module mcc_ctrl_regs_tb_top;
	// revision value is arbitrary
	localparam logic [7:0] REV_CODE = 8'h5A;
	localparam int         LIMIT    = 20000;

	logic       sys_clk = 1'b0;
	logic       rst;
	logic       ser_sel_n, ser_clk, ser_din, ser_dout, ser_oe;
	logic       psm_mode, spd_sig, zero_x;
	logic       pk_a, pk_b, cal, rt_a, rt_b, dbl, c_en, rt_cmd;
	logic       diag_sel, rev_stop, boost_dis, chop, force_hi, comm;
	logic       diag_pin, ob;
	logic [7:0] rd_q;
	logic [7:0] sys_v, tst_v, vcc_v;
	logic [7:0] tv [5] = '{8'h10, 8'h20, 8'h00, 8'h80, 8'h00};
	int         error_cnt = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         b, m;

	always #25 sys_clk = ~sys_clk;

	// outputs gathered in register bit order
	assign sys_v = {rt_cmd, rt_b, c_en, dbl, rt_a, cal, pk_b, pk_a};
	assign tst_v = {boost_dis, 1'b0, rev_stop, diag_sel, 4'h0};
	assign vcc_v = {4'h0, comm, 1'b0, force_hi, chop};

	mcc_ctrl_regs #(.REVISION(REV_CODE)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .ser_sel_n(ser_sel_n),
		.ser_clk(ser_clk), .ser_din(ser_din), .ser_dout(ser_dout),
		.ser_oe(ser_oe), .psm_mode(psm_mode),
		.spindle_speed_sig(spd_sig), .spindle_zero_cross(zero_x),
		.park_level_sel_a(pk_a), .park_level_sel_b(pk_b),
		.calib_reference_connect(cal), .retract_duration_sel_a(rt_a),
		.retract_duration_sel_b(rt_b), .start_timing_double(dbl),
		.coil_enable(c_en), .retract_cmd(rt_cmd),
		.diag_output_select(diag_sel), .spindle_reverse_stop(rev_stop),
		.boost_disable(boost_dis), .coil_chop_slew_sel(chop),
		.coil_outputs_force_high(force_hi),
		.commutation_slew_sel(comm), .spindle_diag_output_pin(diag_pin));

	mcc_host_model i_host (
		.sys_clk(sys_clk), .ser_sel_n(ser_sel_n), .ser_clk(ser_clk),
		.ser_din(ser_din), .ser_dout(ser_dout), .ser_oe(ser_oe));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [7:0] got,
			input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one frame, read data left in rd_q, enable timing checked
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
			input int nb);
		i_host.xfer(a, d, nb, rd_q, ob);
		@(negedge sys_clk);
		check("ser_oe_timing", {7'h00, ob}, 8'h00);
	endtask

	// drive the level inputs and let the output flops follow
	task automatic settle(input logic p, input logic s, input logic z);
		@(posedge sys_clk);
		psm_mode <= p;
		spd_sig  <= s;
		zero_x   <= z;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic all_zero(input string nm);
		check(nm, sys_v | tst_v | vcc_v | {7'h00, diag_pin}, 8'h00);
		$display("test %s done", nm);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		psm_mode = 1'b0;
		spd_sig = 1'b0;
		zero_x = 1'b0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		all_zero("reset_values");
		// walking one through system control
		for (b = 0; b < 8; b++) begin
			wr(8'h9E, 8'h01 << b, 16);
			if (b == 3 || b == 6)
				wr(8'h8E, 8'h00, 16);
			check("system_control", sys_v, 8'h01 << b);
		end
		$display("test system_control done");
		// brake set then cleared, unused bits written zero
		for (b = 0; b < 5; b++) begin
			wr(8'hAE, tv[b], 16);
			check("test_control", tst_v, tv[b]);
		end
		$display("test test_control done");
		// diagnostic source follows the select bit
		for (m = 0; m < 2; m++) begin
			wr(8'hAE, m ? 8'h10 : 8'h00, 16);
			for (b = 0; b < 2; b++) begin
				settle(1'b0, b[0], ~b[0]);
				check("diag_pin", {7'h00, diag_pin},
					{7'h00, m[0] ? b[0] : ~b[0]});
			end
		end
		$display("test diag_source done");
		// slew selects, force high only in phase-shift mode
		wr(8'hBE, 8'h09, 16);
		check("coil_slew", vcc_v, 8'h09);
		wr(8'hBE, 8'h02, 16);
		check("coil_force_off", vcc_v, 8'h00);
		settle(1'b1, 1'b0, 1'b0);
		check("coil_force_on", vcc_v, 8'h02);
		settle(1'b0, 1'b0, 1'b0);
		check("coil_force_drop", vcc_v, 8'h00);
		$display("test coil_control done");
		// revision read, write to it refused, aborted frame ignored
		wr(8'hFF, 8'h00, 16);
		check("revision", rd_q, REV_CODE);
		wr(8'hFF, 8'hC3, 16);
		wr(8'h9E, 8'h3C, 15);
		wr(8'hFF, 8'h00, 16);
		check("revision_kept", rd_q, REV_CODE);
		check("system_kept", sys_v, 8'h80);
		$display("test revision done");
		// reset in mid-run clears every control
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		all_zero("mid_reset");
		conclude();
	end
endmodule
